// file: logic/rtcacs_pkg.sv
// rtcacs_pkg: register offsets, field positions, reset values and counts
// assumes: imported by the alarm/control/status core only; its link port uses none of it
package rtcacs_pkg;
    // register offsets on the host port
    localparam logic [7:0] ADDR_ALM1_SEC = 8'h07;
    localparam logic [7:0] ADDR_ALM2_DAY = 8'h0D;
    localparam logic [7:0] ADDR_CONTROL = 8'h0E;
    localparam logic [7:0] ADDR_STATUS = 8'h0F;
    localparam logic [7:0] ADDR_CHARGER = 8'h10;
    // alarm bank slots (offset minus first alarm offset)
    localparam int SLOT_A1_SEC = 0;
    localparam int SLOT_A1_MIN = 1;
    localparam int SLOT_A1_HOUR = 2;
    localparam int SLOT_A1_DAY = 3;
    localparam int SLOT_A2_MIN = 4;
    localparam int SLOT_A2_HOUR = 5;
    localparam int SLOT_A2_DAY = 6;
    localparam int ALARM_SLOTS = 7;
    // field positions
    localparam int MASK_BIT = 7;
    localparam int DAY_SEL_BIT = 6;
    localparam int CTL_OSC_DIS = 7;
    localparam int CTL_BACKUP_OUT = 5;
    localparam int CTL_RATE_HI = 4;
    localparam int CTL_RATE_LO = 3;
    localparam int CTL_OUT_FUNC = 2;
    localparam int CTL_A2_IE = 1;
    localparam int CTL_A1_IE = 0;
    localparam int STS_OSC_STOP = 7;
    localparam int STS_A2_FLAG = 1;
    localparam int STS_A1_FLAG = 0;
    // writable bit masks and reset values
    localparam logic [7:0] CONTROL_WMASK = 8'hBF;
    localparam logic [7:0] CONTROL_RESET = 8'h18;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] CHARGER_RESET = 8'h00;
    localparam logic [7:0] ALARM_RESET = 8'h00;
    localparam logic [3:0] CHARGER_KEY = 4'hA;
    localparam logic [1:0] DIODE_NONE = 2'h1;
    localparam logic [1:0] DIODE_ONE = 2'h2;
    localparam logic [1:0] RES_250 = 2'h1;
    localparam logic [1:0] RES_2K = 2'h2;
    localparam logic [1:0] RES_4K = 2'h3;
    // timebase: 32768 ticks make one second
    localparam int TIMEBASE_HZ = 32768;
    localparam int DIV_BITS = 15;
    localparam logic [14:0] DIV_LAST = 15'h7FFF;
    localparam int TAP_4K = 2;
    localparam int TAP_8K = 1;
    localparam int TAP_1HZ = 14;
    localparam logic [1:0] RATE_1HZ = 2'h0;
    localparam logic [1:0] RATE_4K = 2'h1;
    localparam logic [1:0] RATE_8K = 2'h2;
    localparam logic [1:0] RATE_32K = 2'h3;
endpackage

// file: logic/rtcacs_link_port.sv
// rtcacs_link_port: link-clock side of the host register port
// assumes: the byte engine of the serial slave drives the request pins on link_clk
`timescale 1ns/10ps
`default_nettype none
module rtcacs_link_port (
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic link_req,
    input wire logic link_write,
    input wire logic [7:0] link_addr,
    input wire logic [7:0] link_wdata,
    output logic link_ready,
    output logic link_done,
    output logic [7:0] link_rdata,
    output logic req_toggle,
    output logic req_write,
    output logic [7:0] req_addr,
    output logic [7:0] req_wdata,
    input wire logic ack_toggle,
    input wire logic [7:0] ack_rdata
);
    logic ack_meta, ack_sync, ack_seen, busy, done;
    logic [7:0] rdata;
    logic next_req_toggle, next_req_write, next_ack_seen, next_busy, next_done;
    logic [7:0] next_req_addr, next_req_wdata, next_rdata;

    // --------------------------------------------------------------
    // handshake: request words held stable while the toggle crosses
    // --------------------------------------------------------------
    always_comb begin
        next_req_toggle = req_toggle;
        next_req_write = req_write;
        next_req_addr = req_addr;
        next_req_wdata = req_wdata;
        next_ack_seen = ack_seen;
        next_busy = busy;
        next_done = 1'b0;
        next_rdata = rdata;
        if (!busy && link_req) begin
            next_req_toggle = ~req_toggle;
            next_req_write = link_write;
            next_req_addr = link_addr;
            next_req_wdata = link_wdata;
            next_busy = 1'b1;
        end else if (busy && (ack_sync != ack_seen)) begin
            next_ack_seen = ack_sync;
            next_rdata = ack_rdata; // stable: core changed it in the same cycle as its toggle
            next_busy = 1'b0;
            next_done = 1'b1;
        end
    end

    // registers, plus two-stage synchroniser of the returning toggle
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            ack_seen <= 1'b0;
            req_toggle <= 1'b0;
            req_write <= 1'b0;
            req_addr <= 8'h00;
            req_wdata <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
        end else begin
            ack_meta <= ack_toggle;
            ack_sync <= ack_meta;
            ack_seen <= next_ack_seen;
            req_toggle <= next_req_toggle;
            req_write <= next_req_write;
            req_addr <= next_req_addr;
            req_wdata <= next_req_wdata;
            busy <= next_busy;
            done <= next_done;
            rdata <= next_rdata;
        end
    end

    assign link_ready = ~busy;
    assign link_done = done;
    assign link_rdata = rdata;
endmodule
`default_nettype wire

// file: logic/rtcacs_core.sv
// rtcacs_core: alarm matching, control, status flags, output pin and charger setup
// assumes: time counters come from same-clock logic in BCD; the serial slave
// engine hands register accesses over on its own link clock
//
// Notes on behaviour
// - alarm one masks 1111 every second, 1110 seconds, 1100 minutes and seconds
// - alarm one 1000 adds hours; 0000 adds date or weekday by select
// - alarm two masks 111 once a minute at zero seconds, 110 minutes, 100 hours
// - alarm two 000 adds date or weekday to hours and minutes
// - oscillator runs while disable bit is 0, stops at 1, resets to 0
// - backup enable keeps the output alive on backup, else pin floats
// - rate bits pick 1 Hz, 4.096k, 8.192k or 32.768k; reset 11
// - function bit 0 gives square wave, 1 gives alarm interrupt; reset 0
// - interrupt mode drives pin low while any enabled alarm flag is set
// - disabled flags or square-wave mode never interrupt; enables reset 0
// - oscillator stop flag sets when oscillator stops, including power-up
// - oscillator stop flag holds until written 0; writes never set it
// - alarm flags set on match, cleared by writing 0, 1 leaves them
// - charger enabled only when key nibble equals 1010
// - diode bits 01 no diode, 10 one diode, 00 and 11 disable
// - resistor bits 01 250 ohm, 10 2k, 11 4k, 00 disables
// - charger register resets to zero, charger off
// - alarms compared once per second; interrupt holds until flag or its enable cleared
// - bit 6 of alarm day register picks weekday or date compare
`timescale 1ns/10ps
`default_nettype none
module rtcacs_core (
    input wire logic REF_CLK,
    input wire logic SYS_RST,

    input wire logic LINK_CLK,
    input wire logic LINK_RST,

    input wire logic LINK_REQ,
    input wire logic LINK_WRITE,
    input wire logic [7:0] LINK_ADDR,
    input wire logic [7:0] LINK_WDATA,

    output logic LINK_READY,
    output logic LINK_DONE,
    output logic [7:0] LINK_RDATA,

    input wire logic TIMEBASE_32K,
    input wire logic OSC_FAIL,
    input wire logic MAIN_SUPPLY_FAIL,

    input wire logic [7:0] TIME_SEC,
    input wire logic [7:0] TIME_MIN,
    input wire logic [7:0] TIME_HOUR,
    input wire logic [7:0] TIME_WEEKDAY,
    input wire logic [7:0] TIME_DATE,

    output logic SECOND_TICK,

    output logic OSC_ENABLE,
    output logic WAVE_OR_IRQ_OUT,
    output logic WAVE_OR_IRQ_OE,

    output logic CHARGER_ENABLE,
    output logic CHARGER_DIODE,
    output logic [1:0] CHARGER_RES_SEL
);
    // --------------------------------------------------------------
    // register port crossing
    // --------------------------------------------------------------
    logic req_toggle, req_write, ack_toggle;
    logic [7:0] req_addr, req_wdata, ack_rdata;

    logic req_meta, req_sync, req_seen;
    logic next_ack_toggle, next_req_seen;
    logic [7:0] next_ack_rdata;

    logic access;

    rtcacs_link_port u_link (
        .link_clk(LINK_CLK),
        .link_rst(LINK_RST),

        .link_req(LINK_REQ),
        .link_write(LINK_WRITE),
        .link_addr(LINK_ADDR),
        .link_wdata(LINK_WDATA),

        .link_ready(LINK_READY),
        .link_done(LINK_DONE),
        .link_rdata(LINK_RDATA),

        .req_toggle(req_toggle),
        .req_write(req_write),
        .req_addr(req_addr),
        .req_wdata(req_wdata),
        .ack_toggle(ack_toggle),
        .ack_rdata(ack_rdata)
    );

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [7:0] alarm_bank [rtcacs_pkg::ALARM_SLOTS];
    logic [7:0] next_alarm_bank [rtcacs_pkg::ALARM_SLOTS];

    logic [7:0] control, next_control;

    logic oscillator_stop_flag, next_oscillator_stop_flag;
    logic alarm_one_flag, next_alarm_one_flag;
    logic alarm_two_flag, next_alarm_two_flag;
    logic [7:0] charger_reg, next_charger_reg;

    logic tb_meta, tb_sync, tb_last, fail_meta, fail_sync, supply_meta, supply_sync;

    logic [rtcacs_pkg::DIV_BITS-1:0] divider, next_divider;
    logic tick, next_tick, osc_was_running, next_osc_was_running;
    logic wave_out, next_wave_out, oe_out, next_oe_out;

    logic wr_ctl, wr_sts, wr_chg, alarm_one_hit, alarm_two_hit, osc_running;

    logic [7:0] read_value;

    // field aliases
    logic osc_disable_n, backup_output_enable, rate_select_hi, rate_select_lo;
    logic output_function_select, alarm_two_irq_enable, alarm_one_irq_enable;
    logic [3:0] charger_key;
    logic diode_select_hi, diode_select_lo, resistor_select_hi, resistor_select_lo;

    assign osc_disable_n = control[rtcacs_pkg::CTL_OSC_DIS];
    assign backup_output_enable = control[rtcacs_pkg::CTL_BACKUP_OUT];
    assign rate_select_hi = control[rtcacs_pkg::CTL_RATE_HI];
    assign rate_select_lo = control[rtcacs_pkg::CTL_RATE_LO];
    assign output_function_select = control[rtcacs_pkg::CTL_OUT_FUNC];
    assign alarm_two_irq_enable = control[rtcacs_pkg::CTL_A2_IE];
    assign alarm_one_irq_enable = control[rtcacs_pkg::CTL_A1_IE];

    assign charger_key = charger_reg[7:4];
    assign diode_select_hi = charger_reg[3];
    assign diode_select_lo = charger_reg[2];
    assign resistor_select_hi = charger_reg[1];
    assign resistor_select_lo = charger_reg[0];

    // --------------------------------------------------------------
    // alarm comparison
    // --------------------------------------------------------------
    // one alarm field: masked field always matches, else value equal below the mask
    function automatic logic field_hit(input logic [7:0] alarm, input logic [7:0] now);
        field_hit = alarm[rtcacs_pkg::MASK_BIT] || (alarm[6:0] == now[6:0]);
    endfunction

    // day field: bit 6 picks weekday (1) or date (0), compared in bits 5:0
    function automatic logic day_hit(input logic [7:0] alarm, input logic [7:0] wday,
                                     input logic [7:0] date);
        logic [7:0] pick;
        pick = alarm[rtcacs_pkg::DAY_SEL_BIT] ? wday : date;
        day_hit = alarm[rtcacs_pkg::MASK_BIT] || (alarm[5:0] == pick[5:0]);
    endfunction

    // masks cascade from the low field up, so each field only adds a term
    always_comb begin
        alarm_one_hit = field_hit(alarm_bank[rtcacs_pkg::SLOT_A1_SEC], TIME_SEC)
            && field_hit(alarm_bank[rtcacs_pkg::SLOT_A1_MIN], TIME_MIN)
            && field_hit(alarm_bank[rtcacs_pkg::SLOT_A1_HOUR], TIME_HOUR)
            && day_hit(alarm_bank[rtcacs_pkg::SLOT_A1_DAY], TIME_WEEKDAY, TIME_DATE);

        alarm_two_hit = (TIME_SEC == 8'h00)
            && field_hit(alarm_bank[rtcacs_pkg::SLOT_A2_MIN], TIME_MIN)
            && field_hit(alarm_bank[rtcacs_pkg::SLOT_A2_HOUR], TIME_HOUR)
            && day_hit(alarm_bank[rtcacs_pkg::SLOT_A2_DAY], TIME_WEEKDAY, TIME_DATE);
    end

    // --------------------------------------------------------------
    // register access decode and read mux
    // --------------------------------------------------------------
    always_comb begin
        access = (req_sync != req_seen);

        wr_ctl = access && req_write && (req_addr == rtcacs_pkg::ADDR_CONTROL);
        wr_sts = access && req_write && (req_addr == rtcacs_pkg::ADDR_STATUS);
        wr_chg = access && req_write && (req_addr == rtcacs_pkg::ADDR_CHARGER);

        read_value = 8'h00; // unmapped offsets read zero

        if (req_addr >= rtcacs_pkg::ADDR_ALM1_SEC && req_addr <= rtcacs_pkg::ADDR_ALM2_DAY) begin
            read_value = alarm_bank[3'(req_addr - rtcacs_pkg::ADDR_ALM1_SEC)];
        end else if (req_addr == rtcacs_pkg::ADDR_CONTROL) begin
            read_value = control & rtcacs_pkg::CONTROL_WMASK;
        end else if (req_addr == rtcacs_pkg::ADDR_STATUS) begin
            read_value = {oscillator_stop_flag, 5'h00, alarm_two_flag, alarm_one_flag};
        end else if (req_addr == rtcacs_pkg::ADDR_CHARGER) begin
            read_value = charger_reg;
        end

        next_req_seen = req_sync;
        next_ack_toggle = access ? ~ack_toggle : ack_toggle;
        next_ack_rdata = access ? read_value : ack_rdata;
    end

    // --------------------------------------------------------------
    // register file next values
    // --------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < rtcacs_pkg::ALARM_SLOTS; i++) begin
            next_alarm_bank[i] = alarm_bank[i];
            if (access && req_write && (req_addr == 8'(rtcacs_pkg::ADDR_ALM1_SEC + i))) begin
                next_alarm_bank[i] = req_wdata;
            end
        end

        next_control = wr_ctl ? (req_wdata & rtcacs_pkg::CONTROL_WMASK) : control;
        next_charger_reg = wr_chg ? req_wdata : charger_reg;

        // writing 0 clears, writing 1 keeps; a set in the same cycle wins
        next_oscillator_stop_flag = oscillator_stop_flag;
        next_alarm_one_flag = alarm_one_flag;
        next_alarm_two_flag = alarm_two_flag;

        if (wr_sts) begin
            if (!req_wdata[rtcacs_pkg::STS_OSC_STOP]) next_oscillator_stop_flag = 1'b0;
            if (!req_wdata[rtcacs_pkg::STS_A1_FLAG]) next_alarm_one_flag = 1'b0;
            if (!req_wdata[rtcacs_pkg::STS_A2_FLAG]) next_alarm_two_flag = 1'b0;
        end

        if (osc_was_running && !osc_running) next_oscillator_stop_flag = 1'b1;
        if (tick && alarm_one_hit) next_alarm_one_flag = 1'b1;
        if (tick && alarm_two_hit) next_alarm_two_flag = 1'b1;
    end

    // --------------------------------------------------------------
    // timebase divider, per-second tick and pin output
    // --------------------------------------------------------------
    always_comb begin
        osc_running = !osc_disable_n && !fail_sync;
        next_osc_was_running = osc_running;

        next_divider = divider;
        next_tick = 1'b0;

        if (osc_running && tb_sync && !tb_last) begin
            next_divider = divider + 1'b1;
            next_tick = (divider == rtcacs_pkg::DIV_LAST);
        end

        // square wave taps off the divider; 32k passes the timebase through
        case ({rate_select_hi, rate_select_lo})
            rtcacs_pkg::RATE_1HZ: next_wave_out = divider[rtcacs_pkg::TAP_1HZ];
            rtcacs_pkg::RATE_4K: next_wave_out = divider[rtcacs_pkg::TAP_4K];
            rtcacs_pkg::RATE_8K: next_wave_out = divider[rtcacs_pkg::TAP_8K];
            default: next_wave_out = tb_sync & osc_running;
        endcase

        if (output_function_select) begin
            // active low while any enabled flag is set; disabled flags ignored
            next_wave_out = !((alarm_one_flag && alarm_one_irq_enable)
                || (alarm_two_flag && alarm_two_irq_enable));
        end

        next_oe_out = !supply_sync || backup_output_enable;
    end

    // --------------------------------------------------------------
    // registers of the reference domain
    // --------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < rtcacs_pkg::ALARM_SLOTS; i++) begin
                alarm_bank[i] <= rtcacs_pkg::ALARM_RESET;
            end

            control <= rtcacs_pkg::CONTROL_RESET;
            oscillator_stop_flag <= rtcacs_pkg::STATUS_RESET[rtcacs_pkg::STS_OSC_STOP];
            alarm_one_flag <= 1'b0;
            alarm_two_flag <= 1'b0;
            charger_reg <= rtcacs_pkg::CHARGER_RESET;

            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_seen <= 1'b0;
            ack_toggle <= 1'b0;
            ack_rdata <= 8'h00;

            tb_meta <= 1'b0;
            tb_sync <= 1'b0;
            tb_last <= 1'b0;

            fail_meta <= 1'b0;
            fail_sync <= 1'b0;
            supply_meta <= 1'b0;
            supply_sync <= 1'b0;

            divider <= '0;
            tick <= 1'b0;
            osc_was_running <= 1'b0;
            wave_out <= 1'b1;
            oe_out <= 1'b1;
        end else begin
            alarm_bank <= next_alarm_bank;

            control <= next_control;
            oscillator_stop_flag <= next_oscillator_stop_flag;
            alarm_one_flag <= next_alarm_one_flag;
            alarm_two_flag <= next_alarm_two_flag;
            charger_reg <= next_charger_reg;

            req_meta <= req_toggle;
            req_sync <= req_meta;
            req_seen <= next_req_seen;
            ack_toggle <= next_ack_toggle;
            ack_rdata <= next_ack_rdata;

            tb_meta <= TIMEBASE_32K;
            tb_sync <= tb_meta;
            tb_last <= tb_sync;

            fail_meta <= OSC_FAIL;
            fail_sync <= fail_meta;
            supply_meta <= MAIN_SUPPLY_FAIL;
            supply_sync <= supply_meta;

            divider <= next_divider;
            tick <= next_tick;
            osc_was_running <= next_osc_was_running;
            wave_out <= next_wave_out;
            oe_out <= next_oe_out;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    // charger needs the key plus a legal diode and resistor choice
    assign CHARGER_ENABLE = (charger_key == rtcacs_pkg::CHARGER_KEY)
        && (({diode_select_hi, diode_select_lo} == rtcacs_pkg::DIODE_NONE)
            || ({diode_select_hi, diode_select_lo} == rtcacs_pkg::DIODE_ONE))
        && ({resistor_select_hi, resistor_select_lo} != 2'h0);
    assign CHARGER_DIODE = ({diode_select_hi, diode_select_lo} == rtcacs_pkg::DIODE_ONE);
    assign CHARGER_RES_SEL = {resistor_select_hi, resistor_select_lo};

    assign OSC_ENABLE = !osc_disable_n;

    assign SECOND_TICK = tick;
    assign WAVE_OR_IRQ_OUT = wave_out;
    assign WAVE_OR_IRQ_OE = oe_out;
endmodule
`default_nettype wire

// file: bench/rtcacs_core_monitor.sv
// rtcacs_core_monitor: port-level assertions for the alarm/control core
// assumes: bound to rtcacs_core from the bench top file
`timescale 1ns/10ps
`default_nettype none
module rtcacs_core_monitor (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic LINK_CLK,
    input wire logic LINK_RST,
    input wire logic LINK_REQ,
    input wire logic LINK_READY,
    input wire logic LINK_DONE,
    input wire logic [7:0] LINK_RDATA,
    input wire logic MAIN_SUPPLY_FAIL,
    input wire logic SECOND_TICK,
    input wire logic OSC_ENABLE,
    input wire logic WAVE_OR_IRQ_OE,
    input wire logic CHARGER_ENABLE,
    input wire logic [1:0] CHARGER_RES_SEL
);
    // ------------------------------------------------------------
    // register port on the link clock
    // ------------------------------------------------------------
    ready_drop_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
        LINK_REQ && LINK_READY |=> !LINK_READY) else $error("ready high after take");
    take_done_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
        LINK_REQ && LINK_READY |-> ##[1:80] LINK_DONE) else $error("no done after take");
    done_pulse_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
        LINK_DONE |=> !LINK_DONE) else $error("done longer than one cycle");
    done_ready_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
        LINK_DONE |-> LINK_READY) else $error("ready low in done cycle");
    rdata_hold_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
        $changed(LINK_RDATA) |-> LINK_DONE) else $error("read data moved without done");
    // ------------------------------------------------------------
    // reference clock side
    // ------------------------------------------------------------
    tick_gap_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        SECOND_TICK |=> !SECOND_TICK [*8]) else $error("second ticks too close");
    charger_res_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        CHARGER_ENABLE |-> CHARGER_RES_SEL != 2'h0) else $error("charger on, no resistor");
    reset_out_a: assert property (@(posedge REF_CLK)
        SYS_RST |=> OSC_ENABLE && WAVE_OR_IRQ_OE && !CHARGER_ENABLE)
        else $error("outputs wrong after reset");
    oe_backup_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !MAIN_SUPPLY_FAIL [*4] |-> WAVE_OR_IRQ_OE) else $error("pin floats on main supply");
    // main scenarios reached
    cover property (@(posedge LINK_CLK) LINK_REQ && LINK_READY);
    cover property (@(posedge REF_CLK) SECOND_TICK);
    cover property (@(posedge REF_CLK) CHARGER_ENABLE);
endmodule
`default_nettype wire

// file: bench/rtcacs_host_model.sv
// rtcacs_host_model: host byte engine side, one register access at a time
// assumes: bench calls access(); signals change just after a link clock edge
`timescale 1ns/10ps
`default_nettype none
module rtcacs_host_model (
    input wire logic clk,
    input wire logic ready,
    input wire logic done,
    input wire logic [7:0] rdata,
    output logic req,
    output logic wr,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    // idle request lines at time zero
    initial begin
        req = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // hold the request until taken, release, then wait for done
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q);
        int n;
        logic s;
        n = 0;
        s = 1'b0;
        @(posedge clk);
        #1;
        req = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        while (!s && n < 80) begin
            @(negedge clk);
            s = (ready === 1'b1);
            n++;
            @(posedge clk);
        end
        #1;
        req = 1'b0;
        addr = ~a; // released lines do not keep the last value
        wdata = ~d;
        s = 1'b0;
        while (!s && n < 160) begin
            @(negedge clk);
            s = (done === 1'b1);
            q = rdata;
            n++;
            @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// file: bench/rtcacs_core_bench.sv
// rtcacs_core_bench: self-checking bench for the alarm/control core
// assumes: host model drives the link port; time inputs held by the bench
`timescale 1ns/10ps
`default_nettype none
module rtcacs_core_bench;
    logic ref_clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, link_rst = 1'b1, tb32 = 1'b0;
    logic msf = 1'b0, ofl = 1'b0;
    logic [7:0] sec = 8'h59;
    logic req, wr, ready, done, tick, osc_en, pin, oe, chg_en, chg_d;
    logic [7:0] addr, wdata, rdata, q;
    logic [1:0] chg_r;
    int errors = 0, checked = 0, cycles = 0;
    // clocks: reference 100 ns, link 6 ns with its own phase
    initial forever #50 ref_clk = ~ref_clk;
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    // fast timebase and run limit
    always @(posedge ref_clk) begin
        #1 tb32 = ~tb32;
        cycles++;
        if (cycles == 90000) begin
            errors++;
            stop_test();
        end
    end
    rtcacs_host_model rtcacs_host_model_inst (.clk(link_clk), .ready(ready), .done(done),
        .rdata(rdata), .req(req), .wr(wr), .addr(addr), .wdata(wdata));
    rtcacs_core rtcacs_core_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .LINK_CLK(link_clk),
        .LINK_RST(link_rst), .LINK_REQ(req), .LINK_WRITE(wr), .LINK_ADDR(addr),
        .LINK_WDATA(wdata), .LINK_READY(ready), .LINK_DONE(done), .LINK_RDATA(rdata),
        .TIMEBASE_32K(tb32), .OSC_FAIL(ofl), .MAIN_SUPPLY_FAIL(msf), .TIME_SEC(sec),
        .TIME_MIN(8'h00), .TIME_HOUR(8'h00), .TIME_WEEKDAY(8'h00), .TIME_DATE(8'h00),
        .SECOND_TICK(tick), .OSC_ENABLE(osc_en), .WAVE_OR_IRQ_OUT(pin),
        .WAVE_OR_IRQ_OE(oe), .CHARGER_ENABLE(chg_en), .CHARGER_DIODE(chg_d),
        .CHARGER_RES_SEL(chg_r));
    // shared compare, access and wait helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rtcacs_host_model_inst.access(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wt(input logic [7:0] a, input logic [7:0] d);
        rtcacs_host_model_inst.access(1'b1, a, d, q);
    endtask
    task automatic waitn(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // power-up values and an unmapped offset
    task automatic t_reset();
        rd(8'h0E, 8'h18);
        rd(8'h0F, 8'h80);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h00);
        chk({6'h00, osc_en, chg_en}, 8'h02);
    endtask
    // key, diode and resistor decode; wrong key and illegal choices stay off
    task automatic t_charger();
        logic [7:0] v [6] = '{8'hA5, 8'hAB, 8'hA6, 8'hAD, 8'hA4, 8'h55};
        logic [7:0] e [6] = '{8'h09, 8'h0F, 8'h0A, 8'h01, 8'h00, 8'h01};
        for (int i = 0; i < 6; i++) begin
            wt(8'h10, v[i]);
            rd(8'h10, v[i]);
            chk({4'h0, chg_en, chg_d, chg_r}, e[i]);
        end
    endtask
    // both alarms on widest masks, interrupt pin and flag clearing
    task automatic t_alarm();
        sec = 8'h00;
        for (int a = 7; a < 14; a++) wt(a[7:0], 8'h80);
        wt(8'h0E, 8'h07);
        while (tick !== 1'b1) waitn(1);
        waitn(3);
        chk({7'h00, pin}, 8'h00);
        rd(8'h0F, 8'h83);
        wt(8'h0F, 8'h83);
        rd(8'h0F, 8'h83);
        wt(8'h0F, 8'h82);
        rd(8'h0F, 8'h82);
        waitn(3);
        chk({7'h00, pin}, 8'h00);
        wt(8'h0E, 8'h05);
        waitn(3);
        chk({7'h00, pin}, 8'h01);
        wt(8'h0E, 8'h07);
        wt(8'h0F, 8'h80);
        waitn(3);
        chk({7'h00, pin}, 8'h01);
    endtask
    // stop flag clear-only, set on disable; unused bits read zero
    task automatic t_osc();
        wt(8'h0F, 8'h00);
        rd(8'h0F, 8'h00);
        wt(8'h0F, 8'hFF);
        rd(8'h0F, 8'h00);
        wt(8'h0E, 8'hFF);
        waitn(4);
        rd(8'h0E, 8'hBF);
        chk({7'h00, osc_en}, 8'h00);
        rd(8'h0F, 8'h80);
        wt(8'h0E, 8'h00);
        chk({7'h00, osc_en}, 8'h01);
    endtask
    // pin floats on supply loss unless backup output enabled
    task automatic t_backup();
        wt(8'h0F, 8'h00);
        msf = 1'b1;
        ofl = 1'b1;
        waitn(5);
        chk({7'h00, oe}, 8'h00);
        rd(8'h0F, 8'h80);
        wt(8'h0E, 8'h20);
        waitn(5);
        chk({7'h00, oe}, 8'h01);
    endtask
    task automatic stop_test();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        link_rst = 1'b0;
        t_reset();
        t_charger();
        t_alarm();
        t_osc();
        t_backup();
        stop_test();
    end
endmodule
bind rtcacs_core rtcacs_core_monitor rtcacs_core_monitor_inst (.REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST), .LINK_CLK(LINK_CLK), .LINK_RST(LINK_RST), .LINK_REQ(LINK_REQ),
    .LINK_READY(LINK_READY), .LINK_DONE(LINK_DONE), .LINK_RDATA(LINK_RDATA),
    .MAIN_SUPPLY_FAIL(MAIN_SUPPLY_FAIL), .SECOND_TICK(SECOND_TICK), .OSC_ENABLE(OSC_ENABLE),
    .WAVE_OR_IRQ_OE(WAVE_OR_IRQ_OE), .CHARGER_ENABLE(CHARGER_ENABLE),
    .CHARGER_RES_SEL(CHARGER_RES_SEL));
`default_nettype wire
